// File: include/torque_limit_consts.svh
`ifndef TORQUE_LIMIT_CONSTS_SVH
`define TORQUE_LIMIT_CONSTS_SVH

// register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_INT_FWD 8'h04
`define ADDR_INT_REV 8'h08
`define ADDR_EXT_FWD 8'h0c
`define ADDR_EXT_REV 8'h10
`define ADDR_GAIN 8'h14
`define ADDR_IN_MAP 8'h18
`define ADDR_OUT_MAP 8'h1c
`define ADDR_MAX_TRQ 8'h20
`define ADDR_STATE 8'h24
`define ADDR_LIMITS 8'h28
`define ADDR_IRQ_STAT 8'h2c
`define ADDR_IRQ_CLR 8'h30
`define ADDR_IRQ_EN 8'h34

// field positions
`define CTRL_COMB_BIT 0
`define CTRL_DUAL_BIT 1
`define CTRL_AXIS_B_BIT 2
`define IN_MAP_REV_LSB 8
`define OUT_MAP_EN_BIT 8
`define LIMITS_REV_LSB 16
`define IRQ_LIMIT_BIT 0
`define IRQ_FWD_BIT 1
`define IRQ_REV_BIT 2

// reset values and scaling constants; limit values in percent of rated torque
`define RST_INT_LIMIT 9'h12c
`define RST_EXT_LIMIT 9'h064
`define RST_MAX_TRQ 9'h12c
`define PCT_CEIL 9'h12c
`define RST_GAIN 16'h0100
`define GAIN_SHIFT 8
`define RST_FWD_MASK 8'h40
`define RST_REV_MASK 8'h80
`define RST_OUT_SEL 2'h0

// timing
`define CLK_PERIOD_NS 20
`define CTRL_PERIOD_NS 1000
`define CTRL_DIV (`CTRL_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// File: include/torque_limit_pkg.sv
package torque_limit_pkg;
	typedef logic [8:0] pct_t;

	typedef struct packed {
		pct_t intl;
		pct_t ext;
	} dir_cfg_t;

	typedef struct packed {
		logic axis_b;
		logic dual_axis;
		logic comb;
	} ctrl_t;

	typedef struct packed {
		logic [7:0] rev_mask;
		logic [7:0] fwd_mask;
		logic out_en;
		logic [1:0] out_sel;
	} term_map_t;
endpackage

// File: src/limit_pick.sv
`timescale 1ns/100ps
`default_nettype none
`include "torque_limit_consts.svh"

module limit_pick (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// selection inputs
	input wire logic tick,
	input wire logic req_on,
	input wire logic comb,
	input wire torque_limit_pkg::dir_cfg_t cfg,
	input wire torque_limit_pkg::pct_t ana_pct,
	input wire torque_limit_pkg::pct_t cap,
	// chosen limit
	output torque_limit_pkg::pct_t limit
);
	import torque_limit_pkg::*;

	function automatic pct_t pct_min(input pct_t a, input pct_t b);
		pct_min = (a < b) ? a : b;
	endfunction

	wire pct_t sel_plain = req_on ? pct_min(cfg.intl, cfg.ext) : cfg.intl;
	wire pct_t sel_comb = req_on ? pct_min(ana_pct, cfg.ext) : pct_min(cfg.intl, ana_pct);
	wire pct_t sel = comb ? sel_comb : sel_plain;
	wire pct_t next_limit = pct_min(sel, cap);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			limit <= `RST_INT_LIMIT;
		end else if (tick) begin
			limit <= next_limit;
		end
	end
endmodule // limit_pick

`default_nettype wire

// File: src/servo_torque_limit_select.sv
`timescale 1ns/100ps
`default_nettype none
`include "torque_limit_consts.svh"

// Operation
// - forward request on: min of internal and external forward; off: internal only.
// - reverse request on: min of internal and external reverse; off: internal only.
// - both limit request inputs are active low.
// - combined option runs external-input and analog limits together.
// - combined, request on: min of analog limit and that direction's external setting.
// - combined option routes analog input as limit source, with request on or off.
// - analog input used as limit is never also a torque command.
// - analog input is scaled by a programmable input gain.
// - analog input exists on first axis only; second axis ignores it.
// - single-axis unit uses general inputs seven and eight for the requests.
// - dual-axis unit picks request terminals from an input allocation setting.
// - functions sharing a terminal follow it; several terminals combine by OR.
// - torque-limited output low while torque is limited, high otherwise.
// - torque-limited output reaches a terminal only once one is allocated.
// - analog limit uses absolute voltage, applied to both directions.
// - limit settings are percent of rated torque, rated equals one hundred.
module servo_torque_limit_select #(
	parameter int CTRL_DIV = `CTRL_DIV
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// input terminals and analog
	input wire logic [7:0] gp_in_n,
	input wire logic [15:0] analog_ch2_pos,
	input wire logic [15:0] torque_demand,
	// output terminals
	output logic [3:0] out_term_n,
	// limits and command to the current loop
	output torque_limit_pkg::pct_t fwd_limit,
	output torque_limit_pkg::pct_t rev_limit,
	output logic [15:0] torque_cmd,
	// interrupt
	output logic irq
);
	import torque_limit_pkg::*;

	ctrl_t ctrl;
	dir_cfg_t fwd_cfg;
	dir_cfg_t rev_cfg;
	term_map_t tmap;
	logic [15:0] gain;
	pct_t max_trq;
	logic [2:0] irq_stat;
	logic [2:0] irq_en;
	logic [15:0] div_cnt;
	logic tick;
	logic fwd_on_q;
	logic rev_on_q;
	logic torque_limited_n;

	function automatic logic hit(input logic [7:0] a);
		hit = wr_en && (addr == a);
	endfunction

	// control cycle divider
	wire logic div_end = (div_cnt == 16'(CTRL_DIV - 1));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			div_cnt <= div_end ? 16'h0000 : div_cnt + 16'h0001;
			tick <= div_end;
		end
	end

	// register writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl <= '0;
			fwd_cfg <= {`RST_INT_LIMIT, `RST_EXT_LIMIT};
			rev_cfg <= {`RST_INT_LIMIT, `RST_EXT_LIMIT};
			gain <= `RST_GAIN;
			tmap <= {`RST_REV_MASK, `RST_FWD_MASK, 1'b0, `RST_OUT_SEL};
			max_trq <= `RST_MAX_TRQ;
			irq_en <= 3'h0;
		end else begin
			if (hit(`ADDR_CTRL)) begin
				ctrl <= {wr_data[`CTRL_AXIS_B_BIT], wr_data[`CTRL_DUAL_BIT], wr_data[`CTRL_COMB_BIT]};
			end
			if (hit(`ADDR_INT_FWD)) begin
				fwd_cfg.intl <= wr_data[8:0];
			end
			if (hit(`ADDR_INT_REV)) begin
				rev_cfg.intl <= wr_data[8:0];
			end
			if (hit(`ADDR_EXT_FWD)) begin
				fwd_cfg.ext <= wr_data[8:0];
			end
			if (hit(`ADDR_EXT_REV)) begin
				rev_cfg.ext <= wr_data[8:0];
			end
			if (hit(`ADDR_GAIN)) begin
				gain <= wr_data[15:0];
			end
			if (hit(`ADDR_IN_MAP)) begin
				tmap.fwd_mask <= wr_data[7:0];
				tmap.rev_mask <= wr_data[`IN_MAP_REV_LSB +: 8];
			end
			if (hit(`ADDR_OUT_MAP)) begin
				tmap.out_sel <= wr_data[1:0];
				tmap.out_en <= wr_data[`OUT_MAP_EN_BIT];
			end
			if (hit(`ADDR_MAX_TRQ)) begin
				max_trq <= wr_data[8:0];
			end
			if (hit(`ADDR_IRQ_EN)) begin
				irq_en <= wr_data[2:0];
			end
		end
	end

	// terminal mapping: fixed seven/eight on single axis, allocated on dual axis
	wire logic [7:0] fwd_mask = ctrl.dual_axis ? tmap.fwd_mask : `RST_FWD_MASK;
	wire logic [7:0] rev_mask = ctrl.dual_axis ? tmap.rev_mask : `RST_REV_MASK;
	// low level is on; any mapped terminal on turns the function on
	wire logic fwd_on = |(~gp_in_n & fwd_mask);
	wire logic rev_on = |(~gp_in_n & rev_mask);

	// analog channel: absolute value, gain, saturate to percent
	wire logic ana_avail = !ctrl.axis_b;
	wire logic [15:0] ana_abs = analog_ch2_pos[15] ? 16'(-analog_ch2_pos) : analog_ch2_pos;
	wire logic [31:0] ana_prod = ana_abs * gain;
	wire logic [23:0] ana_scaled = ana_prod[`GAIN_SHIFT +: 24];
	wire pct_t ana_sat = (|ana_scaled[23:9]) ? 9'h1ff : ana_scaled[8:0];
	wire pct_t ana_pct = ana_avail ? ana_sat : `PCT_CEIL;
	wire logic comb_on = ctrl.comb && ana_avail;
	wire pct_t cap = (max_trq < `PCT_CEIL) ? max_trq : `PCT_CEIL;

	// signed command path when analog is not a limit source
	wire logic signed [31:0] cmd_prod = $signed(analog_ch2_pos) * $signed({1'b0, gain[14:0]});
	wire logic [15:0] next_torque_cmd = (ctrl.comb || !ana_avail) ? 16'h0000 :
		16'(cmd_prod[`GAIN_SHIFT +: 16]);

	generate
		for (genvar d = 0; d < 2; d++) begin : g_dir
			pct_t lim;
			limit_pick u_pick (
				.core_clk(core_clk),
				.rst(rst),
				.tick(tick),
				.req_on(d == 0 ? fwd_on : rev_on),
				.comb(comb_on),
				.cfg(d == 0 ? fwd_cfg : rev_cfg),
				.ana_pct(ana_pct),
				.cap(cap),
				.limit(lim)
			);
		end
	endgenerate

	assign fwd_limit = g_dir[0].lim;
	assign rev_limit = g_dir[1].lim;

	// limited when demand reaches the active limit in its direction
	wire logic signed [15:0] dem = $signed(torque_demand);
	wire logic signed [15:0] fwd_s = $signed({7'h00, fwd_limit});
	wire logic signed [15:0] rev_s = -$signed({7'h00, rev_limit});
	wire logic at_limit = (dem >= fwd_s && !dem[15]) || (dem <= rev_s && dem[15]);

	// events
	wire logic ev_limit = tick && at_limit && torque_limited_n;
	wire logic ev_fwd = tick && fwd_on && !fwd_on_q;
	wire logic ev_rev = tick && rev_on && !rev_on_q;
	wire logic [2:0] ev = {ev_rev, ev_fwd, ev_limit};
	wire logic [2:0] irq_clr = (wr_en && addr == `ADDR_IRQ_CLR) ? wr_data[2:0] : 3'h0;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			torque_limited_n <= 1'b1;
			fwd_on_q <= 1'b0;
			rev_on_q <= 1'b0;
			irq_stat <= 3'h0;
			irq <= 1'b0;
			torque_cmd <= 16'h0000;
		end else begin
			if (tick) begin
				torque_limited_n <= !at_limit;
				fwd_on_q <= fwd_on;
				rev_on_q <= rev_on;
			end
			irq_stat <= (irq_stat & ~irq_clr) | ev;
			irq <= |(irq_stat & irq_en);
			torque_cmd <= next_torque_cmd;
		end
	end

	// output terminals: idle high, allocated one carries the limited flag
	wire logic [3:0] next_out_term_n;
	generate
		for (genvar t = 0; t < 4; t++) begin : g_out
			assign next_out_term_n[t] = (tmap.out_en && tmap.out_sel == 2'(t)) ?
				torque_limited_n : 1'b1;
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_term_n <= 4'hf;
		end else begin
			out_term_n <= next_out_term_n;
		end
	end

	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (addr)
			`ADDR_CTRL: rd_mux = {29'h0, ctrl};
			`ADDR_INT_FWD: rd_mux = {23'h0, fwd_cfg.intl};
			`ADDR_INT_REV: rd_mux = {23'h0, rev_cfg.intl};
			`ADDR_EXT_FWD: rd_mux = {23'h0, fwd_cfg.ext};
			`ADDR_EXT_REV: rd_mux = {23'h0, rev_cfg.ext};
			`ADDR_GAIN: rd_mux = {16'h0, gain};
			`ADDR_IN_MAP: rd_mux = {16'h0, tmap.rev_mask, tmap.fwd_mask};
			`ADDR_OUT_MAP: rd_mux = {23'h0, tmap.out_en, 6'h0, tmap.out_sel};
			`ADDR_MAX_TRQ: rd_mux = {23'h0, max_trq};
			`ADDR_STATE: rd_mux = {29'h0, !torque_limited_n, rev_on_q, fwd_on_q};
			`ADDR_LIMITS: rd_mux = {7'h0, rev_limit, 7'h0, fwd_limit};
			`ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat};
			`ADDR_IRQ_EN: rd_mux = {29'h0, irq_en};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= rd_en ? rd_mux : 32'h0000_0000;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_FWD_PLAIN: assert property (
		tick && !comb_on |=> fwd_limit == (($past(fwd_on) && $past(fwd_cfg.ext) < $past(fwd_cfg.intl)
			? $past(fwd_cfg.ext) : $past(fwd_cfg.intl)) < $past(cap)
			? ($past(fwd_on) && $past(fwd_cfg.ext) < $past(fwd_cfg.intl)
			? $past(fwd_cfg.ext) : $past(fwd_cfg.intl)) : $past(cap)))
		else $error("forward limit wrong in plain mode");
	AST_REV_OFF: assert property (
		tick && !comb_on && !rev_on && rev_cfg.intl <= cap |=> rev_limit == $past(rev_cfg.intl))
		else $error("reverse limit not internal when request off");
	AST_REV_ON: assert property (
		tick && !comb_on && rev_on |=> rev_limit <= $past(rev_cfg.ext) && rev_limit <= $past(rev_cfg.intl))
		else $error("reverse limit above a setting while request on");
	AST_REQ_LOW: assert property (
		tick && !ctrl.dual_axis && gp_in_n[6] |=> !fwd_on_q)
		else $error("high terminal seen as forward request");
	AST_COMB: assert property (
		tick && comb_on && fwd_on |=> fwd_limit <= $past(ana_pct) && fwd_limit <= $past(fwd_cfg.ext))
		else $error("combined forward limit above analog or external");
	AST_CMD_BLOCK: assert property (
		ctrl.comb ##1 ctrl.comb |-> torque_cmd == 16'h0000)
		else $error("analog used as command while it is a limit");
	AST_AXIS_B: assert property (
		ctrl.axis_b ##1 ctrl.axis_b |-> torque_cmd == 16'h0000)
		else $error("second axis used analog input");
	AST_CAP: assert property (
		tick |=> fwd_limit <= `PCT_CEIL && rev_limit <= `PCT_CEIL && fwd_limit <= $past(max_trq))
		else $error("limit above ceiling or motor maximum");
	AST_LIMITED: assert property (
		tick && at_limit |=> !torque_limited_n
			##1 (!$past(tmap.out_en) || out_term_n[$past(tmap.out_sel)] == 1'b0))
		else $error("limited flag not shown");
	AST_NO_ALLOC: assert property (
		!tmap.out_en |=> out_term_n == 4'hf)
		else $error("limited flag driven without allocation");
	AST_TICK: assert property (
		tick |=> (!tick) [*8])
		else $error("control cycle pulses too close");
endmodule // servo_torque_limit_select

`default_nettype wire

// File: verification/ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none

// machine controller side: drives limit requests onto the input terminals
module ctrl_model (
	// clock
	input wire logic core_clk,
	// commands from the bench
	input wire logic fwd_on,
	input wire logic rev_on,
	input wire logic [7:0] other_on,
	// input terminals of the drive
	output logic [7:0] gp_in_n
);
	initial gp_in_n = 8'hff;
	// other_on is ORed onto all eight inputs, seven and eight included
	always @(posedge core_clk) begin
		gp_in_n <= ~(other_on | {rev_on, fwd_on, 6'h00});
	end
endmodule // ctrl_model

`default_nettype wire

// File: verification/tb_servo_torque_limit_select.sv
`timescale 1ns/100ps
`default_nettype none
`include "torque_limit_consts.svh"

module tb_servo_torque_limit_select;
	import torque_limit_pkg::*;
	localparam int DIV = 10;
	typedef struct packed {
		logic comb;
		logic fon;
		logic ron;
		pct_t intf;
		pct_t intr;
		pct_t extf;
		pct_t extr;
		logic [15:0] ana;
		pct_t ef;
		pct_t er;
	} row_t;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rd_data;
	logic [7:0] gp_in_n;
	logic [15:0] analog_ch2_pos = 16'h0000;
	logic [15:0] torque_demand = 16'h0000;
	logic [3:0] out_term_n;
	pct_t fwd_limit;
	pct_t rev_limit;
	logic [15:0] torque_cmd;
	logic irq;
	logic fwd_on = 1'b0;
	logic rev_on = 1'b0;
	logic [7:0] other_on = 8'h00;
	int fail_count = 0;
	int n_compared = 0;
	row_t rows [7];

	always #10 core_clk = ~core_clk;

	servo_torque_limit_select #(.CTRL_DIV(DIV)) i_dut (.core_clk(core_clk), .rst(rst),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.gp_in_n(gp_in_n), .analog_ch2_pos(analog_ch2_pos), .torque_demand(torque_demand),
		.out_term_n(out_term_n), .fwd_limit(fwd_limit), .rev_limit(rev_limit),
		.torque_cmd(torque_cmd), .irq(irq));
	ctrl_model i_ctrl (.core_clk(core_clk), .fwd_on(fwd_on), .rev_on(rev_on),
		.other_on(other_on), .gp_in_n(gp_in_n));

	task automatic give_verdict();
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// two control ticks, so the new limit and flag have settled
	task automatic settle();
		repeat (2 * DIV + 4) @(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data, exp);
	endtask

	initial begin
		repeat (10000) @(posedge core_clk);
		fail_count++;
		give_verdict();
	end

	initial begin
		rows[0] = {3'b000, 9'h0c8, 9'h0fa, 9'h064, 9'h078, 16'h0050, 9'h0c8, 9'h0fa};
		rows[1] = {3'b010, 9'h0c8, 9'h0fa, 9'h064, 9'h078, 16'h0050, 9'h064, 9'h0fa};
		rows[2] = {3'b001, 9'h0c8, 9'h0fa, 9'h064, 9'h078, 16'h0050, 9'h0c8, 9'h078};
		rows[3] = {3'b011, 9'h032, 9'h03c, 9'h064, 9'h078, 16'h0050, 9'h032, 9'h03c};
		rows[4] = {3'b111, 9'h12c, 9'h12c, 9'h064, 9'h078, 16'h0050, 9'h050, 9'h050};
		rows[5] = {3'b100, 9'h0c8, 9'h0fa, 9'h064, 9'h078, 16'hff6a, 9'h096, 9'h096};
		rows[6] = {3'b110, 9'h12c, 9'h12c, 9'h028, 9'h078, 16'hff6a, 9'h028, 9'h096};
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			wr(`ADDR_CTRL, {31'h0, rows[i].comb});
			wr(`ADDR_INT_FWD, {23'h0, rows[i].intf});
			wr(`ADDR_INT_REV, {23'h0, rows[i].intr});
			wr(`ADDR_EXT_FWD, {23'h0, rows[i].extf});
			wr(`ADDR_EXT_REV, {23'h0, rows[i].extr});
			fwd_on <= rows[i].fon;
			rev_on <= rows[i].ron;
			analog_ch2_pos <= rows[i].ana;
			settle();
			chk({23'h0, fwd_limit}, {23'h0, rows[i].ef});
			chk({23'h0, rev_limit}, {23'h0, rows[i].er});
			chk({16'h0, torque_cmd}, rows[i].comb ? 32'h0 : {16'h0, rows[i].ana});
			rdc(`ADDR_LIMITS, {7'h0, rows[i].er, 7'h0, rows[i].ef});
		end
		// limited flag, before and after a terminal is allocated
		wr(`ADDR_CTRL, 32'h0);
		wr(`ADDR_INT_FWD, 32'h0c8);
		fwd_on <= 1'b0;
		rev_on <= 1'b0;
		torque_demand <= 16'h00c8;
		settle();
		chk({28'h0, out_term_n}, 32'hf);
		rdc(`ADDR_STATE, 32'h4);
		wr(`ADDR_OUT_MAP, 32'h102);
		repeat (3) @(posedge core_clk);
		chk({28'h0, out_term_n}, 32'hb);
		torque_demand <= 16'h00c7;
		settle();
		chk({28'h0, out_term_n}, 32'hf);
		torque_demand <= 16'hfed4;
		settle();
		chk({28'h0, out_term_n}, 32'hb);
		torque_demand <= 16'h0000;
		wr(`ADDR_MAX_TRQ, 32'h05a);
		settle();
		chk({23'h0, fwd_limit}, 32'h05a);
		wr(`ADDR_MAX_TRQ, 32'h12c);
		// interrupt raised, masked, cleared
		wr(`ADDR_IRQ_CLR, 32'h7);
		wr(`ADDR_IRQ_EN, 32'h2);
		fwd_on <= 1'b1;
		settle();
		chk({31'h0, irq}, 32'h1);
		rdc(`ADDR_IRQ_STAT, 32'h2);
		wr(`ADDR_IRQ_EN, 32'h0);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr(`ADDR_IRQ_CLR, 32'h2);
		wr(`ADDR_IRQ_EN, 32'h2);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		rdc(`ADDR_IRQ_CLR, 32'h0);
		rdc(8'h3c, 32'h0);
		// dual axis: request terminals come from the allocation mask
		wr(`ADDR_CTRL, 32'h2);
		wr(`ADDR_IN_MAP, 32'h8003);
		wr(`ADDR_EXT_FWD, 32'h064);
		other_on <= 8'h02;
		settle();
		chk({23'h0, fwd_limit}, 32'h064);
		other_on <= 8'h00;
		settle();
		chk({23'h0, fwd_limit}, 32'h0c8);
		wr(`ADDR_CTRL, 32'h0);
		settle();
		chk({23'h0, fwd_limit}, 32'h064);
		wr(`ADDR_CTRL, 32'h7);
		analog_ch2_pos <= 16'h0050;
		settle();
		chk({23'h0, fwd_limit}, 32'h0c8);
		chk({16'h0, torque_cmd}, 32'h0);
		wr(`ADDR_CTRL, 32'h6);
		repeat (3) @(posedge core_clk);
		chk({16'h0, torque_cmd}, 32'h0);
		// reset in mid-run
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1 chk({23'h0, fwd_limit}, 32'h12c);
		chk({28'h0, out_term_n}, 32'hf);
		rdc(`ADDR_EXT_FWD, 32'h064);
		rdc(`ADDR_GAIN, 32'h100);
		rdc(`ADDR_IN_MAP, 32'h8040);
		give_verdict();
	end
endmodule // tb_servo_torque_limit_select

`default_nettype wire
